// ### clock_ctrl_regs.vh
// Register offsets, field positions, reset values and timing figures of the clock block
`ifndef CLOCK_CTRL_REGS_VH
`define CLOCK_CTRL_REGS_VH

// Register byte offsets
`define OFS_LOOP_CTRL 8'h00
`define OFS_INTEGRATOR 8'h04
`define OFS_OSC_CTRL 8'h08
`define OFS_SEL_CTRL 8'h0C
`define OFS_MODE_BITS 8'h10
`define OFS_FAULT 8'h14

// Reset values
`define LOOP_CTRL_RST 8'h1F
`define INTEGRATOR_RST 10'h000
`define OSC_CTRL_RST 8'h02
`define SEL_CTRL_RST 11'h000
`define MODE_BITS_RST 4'h0

// Loop control fields
`define LC_MULT_MSB 6
`define LC_MULT_LSB 0

// Oscillator control fields
`define OC_RANGE_EXT 0
`define OC_LOOP_DIV_MSB 2
`define OC_LOOP_DIV_LSB 1
`define OC_XTAL_MODE 3
`define OC_LOAD_CAP_MSB 5
`define OC_LOAD_CAP_LSB 4
`define OC_AUX_DIV_MSB 7
`define OC_AUX_DIV_LSB 6

// Selection control fields
`define SC_MAIN_SEL_MSB 1
`define SC_MAIN_SEL_LSB 0
`define SC_MAIN_DIV_MSB 3
`define SC_MAIN_DIV_LSB 2
`define SC_SUB_SEL 4
`define SC_SUB_OFF 5
`define SC_SECOND_OFF 6
`define SC_PRI_SRC_MSB 8
`define SC_PRI_SRC_LSB 7
`define SC_SECOND_RANGE_MSB 10
`define SC_SECOND_RANGE_LSB 9

// Mode bit positions
`define MB_LOOP_DISABLE 0
`define MB_SECOND_GEN_OFF 1
`define MB_CRYSTAL_OFF 2
`define MB_PROC_HALT 3

// Fault register bit positions
`define FB_LOW_FREQ 0
`define FB_HF_PRIMARY 1
`define FB_SECOND 2
`define FB_IRQ_FLAG 3

// Encodings
`define PRI_SRC_VLP 2'b10
`define SECOND_EXT_CLOCK 2'b11
`define MAIN_SEL_SECOND 2'b10
`define MAIN_SEL_PRIMARY 2'b11

// Timing figures
`define CLK_FREQ_HZ 125000000
`define PRIMARY_HF_MIN_HZ 450000
`define SECOND_MIN_HZ 450000
`define LOW_FREQ_MIN_HZ 10000

`endif

// ### clock_source_select_gating.v
// Clock source selection, division, gating and frequency lock loop with an APB register file
`timescale 1ns/100ps
`include "clock_ctrl_regs.vh"

module clock_source_select_gating #(
  parameter HAS_SECOND = 1,
  parameter LF_TIMEOUT_CYCLES = `CLK_FREQ_HZ / `LOW_FREQ_MIN_HZ
) (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire primary_crystal_clock,
  input wire very_low_power_clock,
  input wire second_crystal_clock,
  output reg aux_clock,
  output reg aux_clock_out,
  output reg main_clock_cpu,
  output reg main_clock_periph,
  output reg sub_main_clock,
  output reg ring_osc_clock,
  output reg primary_osc_enable,
  output reg primary_hf_mode,
  output reg [1:0] load_capacitance_select,
  output reg very_low_power_enable,
  output reg second_osc_enable,
  output reg second_ext_clock_mode,
  output reg ring_osc_enable
);

  // Longest input periods before a fault is flagged, rounded down
  // Cut to the 16-bit gap counters: a timeout above 65535 cycles would wrap
  localparam [31:0] HF_LIMIT = `CLK_FREQ_HZ / `PRIMARY_HF_MIN_HZ;
  localparam [31:0] SECOND_LIMIT = `CLK_FREQ_HZ / `SECOND_MIN_HZ;
  localparam [31:0] LF_LIMIT = LF_TIMEOUT_CYCLES;
  localparam [15:0] HF_MAX_CYCLES = HF_LIMIT[15:0];
  localparam [15:0] SECOND_MAX_CYCLES = SECOND_LIMIT[15:0];
  localparam [15:0] LF_MAX_CYCLES = LF_LIMIT[15:0];

  reg [7:0] loop_ctrl;
  reg [9:0] integrator;
  reg [7:0] osc_ctrl;
  reg [10:0] sel_ctrl;
  reg [3:0] mode_bits;
  reg low_freq_fault_bit;
  reg hf_primary_fault_bit;
  reg second_osc_fault_bit;
  reg osc_fault_irq_flag;

  // Divided output as a level: ratio 0 passes the source, else a counter bit
  function div_level;
    input src;
    input [2:0] cnt;
    input [1:0] ratio;
    begin
      case (ratio)
        2'd0: div_level = src;
        2'd1: div_level = cnt[0];
        2'd2: div_level = cnt[1];
        default: div_level = cnt[2];
      endcase
    end
  endfunction

  // Field decodes
  wire [6:0] mult_n = loop_ctrl[`LC_MULT_MSB:`LC_MULT_LSB];
  wire range_extend_bit = osc_ctrl[`OC_RANGE_EXT];
  wire [1:0] loop_div = osc_ctrl[`OC_LOOP_DIV_MSB:`OC_LOOP_DIV_LSB];
  wire crystal_frequency_mode_bit = osc_ctrl[`OC_XTAL_MODE];
  wire [1:0] aux_div = osc_ctrl[`OC_AUX_DIV_MSB:`OC_AUX_DIV_LSB];
  wire [1:0] main_clock_select_field = sel_ctrl[`SC_MAIN_SEL_MSB:`SC_MAIN_SEL_LSB];
  wire [1:0] main_div = sel_ctrl[`SC_MAIN_DIV_MSB:`SC_MAIN_DIV_LSB];
  wire sub_main_clock_select = sel_ctrl[`SC_SUB_SEL];
  wire sub_main_clock_off_bit = sel_ctrl[`SC_SUB_OFF];
  wire second_osc_off_bit = sel_ctrl[`SC_SECOND_OFF];
  wire [1:0] primary_osc_source_field = sel_ctrl[`SC_PRI_SRC_MSB:`SC_PRI_SRC_LSB];
  wire [1:0] second_osc_range_field = sel_ctrl[`SC_SECOND_RANGE_MSB:`SC_SECOND_RANGE_LSB];
  wire loop_disable_bit = mode_bits[`MB_LOOP_DISABLE];
  wire second_generator_off_bit = mode_bits[`MB_SECOND_GEN_OFF];
  wire crystal_off_bit = mode_bits[`MB_CRYSTAL_OFF];
  wire processor_halt_bit = mode_bits[`MB_PROC_HALT];

  // Auxiliary source choice
  wire vlp_selected = (primary_osc_source_field == `PRI_SRC_VLP) &&
                      !crystal_frequency_mode_bit;
  wire aux_src = vlp_selected ? very_low_power_clock : primary_crystal_clock;

  // Main source: fault forces the ring clock, setting left untouched
  wire [1:0] main_sel_req = osc_fault_irq_flag ? 2'b00 : main_clock_select_field;
  wire main_uses_primary = (main_clock_select_field == `MAIN_SEL_PRIMARY) && !processor_halt_bit;
  wire main_uses_second = (main_clock_select_field == `MAIN_SEL_SECOND) && !processor_halt_bit;
  wire sub_uses_second = sub_main_clock_select && !sub_main_clock_off_bit && (HAS_SECOND != 0);

  // APB decode; one access cycle, no wait states
  wire setup_phase = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  // Register file; settings may change at any time, main and sub-main selections follow glitch-free
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_ctrl <= `LOOP_CTRL_RST;
      osc_ctrl <= `OSC_CTRL_RST;
      sel_ctrl <= `SEL_CTRL_RST;
      mode_bits <= `MODE_BITS_RST;
    end else if (wr_en) begin
      case (paddr)
        `OFS_LOOP_CTRL: loop_ctrl <= pwdata[7:0];
        `OFS_OSC_CTRL: osc_ctrl <= pwdata[7:0];
        `OFS_SEL_CTRL: sel_ctrl <= pwdata[10:0];
        `OFS_MODE_BITS: mode_bits <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle so they come from flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= 1'b0;
      case (paddr)
        `OFS_LOOP_CTRL: prdata <= {24'h000000, loop_ctrl};
        `OFS_INTEGRATOR: prdata <= {22'h0, integrator};
        `OFS_OSC_CTRL: prdata <= {24'h000000, osc_ctrl};
        `OFS_SEL_CTRL: prdata <= {21'h0, sel_ctrl};
        `OFS_MODE_BITS: prdata <= {28'h0000000, mode_bits};
        `OFS_FAULT: prdata <= {28'h0000000, osc_fault_irq_flag, second_osc_fault_bit,
                              hf_primary_fault_bit, low_freq_fault_bit};
        default: begin
          prdata <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // Oscillator enables and mode pins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primary_osc_enable <= 1'b1;
      primary_hf_mode <= 1'b0;
      load_capacitance_select <= 2'b00;
      very_low_power_enable <= 1'b0;
      second_osc_enable <= 1'b0;
      second_ext_clock_mode <= 1'b0;
      ring_osc_enable <= 1'b1;
    end else begin
      primary_osc_enable <= !vlp_selected &&
                            !(crystal_off_bit && !main_uses_primary);
      primary_hf_mode <= crystal_frequency_mode_bit;
      load_capacitance_select <= osc_ctrl[`OC_LOAD_CAP_MSB:`OC_LOAD_CAP_LSB];
      very_low_power_enable <= vlp_selected && !crystal_off_bit;
      second_osc_enable <= (HAS_SECOND != 0) &&
                           !(second_osc_off_bit && !main_uses_second && !sub_uses_second);
      second_ext_clock_mode <= (second_osc_range_field == `SECOND_EXT_CLOCK);
      // Ring generator stops when halted with its off bit set and sub-main off or on the second crystal, whatever main selects
      ring_osc_enable <= !(second_generator_off_bit && processor_halt_bit &&
                           (sub_uses_second || sub_main_clock_off_bit));
    end
  end

  // Ring oscillator model: phase accumulator whose step follows the integrator
  reg [15:0] ring_phase;
  reg [2:0] ring_div_cnt;
  reg ring_prev;
  reg dco_div;
  reg dco_div_prev;
  wire [15:0] ring_step = {6'h00, integrator} + 16'h0001;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ring_phase <= 16'h0000;
      ring_prev <= 1'b0;
      ring_div_cnt <= 3'h0;
      dco_div <= 1'b0;
      dco_div_prev <= 1'b0;
      ring_osc_clock <= 1'b0;
    end else begin
      if (ring_osc_enable)
        ring_phase <= ring_phase + ring_step;
      ring_prev <= ring_phase[15];
      if (ring_phase[15] && !ring_prev)
        ring_div_cnt <= ring_div_cnt + 3'h1;
      // Divided by D, the ratio used by the loop
      dco_div <= div_level(ring_phase[15], ring_div_cnt, loop_div);
      dco_div_prev <= dco_div;
      // Output tap: undivided when range extend is set, else divided by D
      ring_osc_clock <= range_extend_bit ? ring_phase[15] : dco_div;
    end
  end

  // Frequency lock loop: count divided ring edges over each auxiliary period
  reg aux_prev;
  reg [11:0] edge_count;
  wire aux_rise = aux_src && !aux_prev;
  wire [11:0] target = {5'h00, mult_n} + 12'h001;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_prev <= 1'b0;
      edge_count <= 12'h000;
      integrator <= `INTEGRATOR_RST;
    end else begin
      aux_prev <= aux_src;
      if (aux_rise) begin
        edge_count <= 12'h000;
        // Held value survives while disabled, so re-enable resumes there
        if (!loop_disable_bit) begin
          if (edge_count < target && integrator != 10'h3FF)
            integrator <= integrator + 10'h001;
          else if (edge_count > target && integrator != 10'h000)
            integrator <= integrator - 10'h001;
        end
      end else begin
        if (dco_div && !dco_div_prev && edge_count != 12'hFFF)
          edge_count <= edge_count + 12'h001;
        if (wr_en && paddr == `OFS_INTEGRATOR)
          integrator <= pwdata[9:0];
      end
    end
  end

  // Fault watchdogs: too long between input edges marks the oscillator bad
  reg pri_prev;
  reg sec_prev;
  reg [15:0] pri_gap;
  reg [15:0] sec_gap;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pri_prev <= 1'b0;
      sec_prev <= 1'b0;
      pri_gap <= 16'h0000;
      sec_gap <= 16'h0000;
      low_freq_fault_bit <= 1'b1;
      hf_primary_fault_bit <= 1'b0;
      second_osc_fault_bit <= 1'b0;
    end else begin
      pri_prev <= primary_crystal_clock;
      sec_prev <= second_crystal_clock;
      if (primary_crystal_clock && !pri_prev)
        pri_gap <= 16'h0000;
      else if (pri_gap != 16'hFFFF)
        pri_gap <= pri_gap + 16'h0001;
      if (second_crystal_clock && !sec_prev)
        sec_gap <= 16'h0000;
      else if (sec_gap != 16'hFFFF)
        sec_gap <= sec_gap + 16'h0001;
      // With the primary enabled in low frequency mode, no primary edges keep this set, so a lone second crystal never clears it
      low_freq_fault_bit <= primary_osc_enable && !crystal_frequency_mode_bit &&
                            (pri_gap > LF_MAX_CYCLES);
      hf_primary_fault_bit <= primary_osc_enable && crystal_frequency_mode_bit &&
                              (pri_gap > HF_MAX_CYCLES);
      second_osc_fault_bit <= second_osc_enable &&
                              (sec_gap > SECOND_MAX_CYCLES);
    end
  end

  // Interrupt flag: set at reset and on any fault, cleared by writing one; set wins
  wire any_fault = low_freq_fault_bit || hf_primary_fault_bit || second_osc_fault_bit;
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      osc_fault_irq_flag <= 1'b1;
    else if (any_fault)
      osc_fault_irq_flag <= 1'b1;
    else if (wr_en && paddr == `OFS_FAULT && pwdata[`FB_IRQ_FLAG])
      osc_fault_irq_flag <= 1'b0;
  end

  // Main source level before division, and the undivided sub-main source level
  reg [1:0] main_sel;
  reg sub_sel;
  reg main_src;
  reg sub_src;
  always @* begin
    case (main_sel)
      `MAIN_SEL_PRIMARY: main_src = aux_src;
      `MAIN_SEL_SECOND: main_src = (HAS_SECOND != 0) ? second_crystal_clock : ring_osc_clock;
      default: main_src = ring_osc_clock;
    endcase
    sub_src = (sub_sel && HAS_SECOND != 0) ? second_crystal_clock : ring_osc_clock;
  end

  // Requested source level, used to wait until old and new are both low
  reg main_req_src;
  always @* begin
    case (main_sel_req)
      `MAIN_SEL_PRIMARY: main_req_src = aux_src;
      `MAIN_SEL_SECOND: main_req_src = (HAS_SECOND != 0) ? second_crystal_clock : ring_osc_clock;
      default: main_req_src = ring_osc_clock;
    endcase
  end
  wire sub_req_src = (sub_main_clock_select && HAS_SECOND != 0) ?
                     second_crystal_clock : ring_osc_clock;

  // Dividers count source rising edges; ratio changes land only at a wrap
  reg [2:0] aux_cnt;
  reg [2:0] main_cnt;
  reg [1:0] aux_ratio;
  reg [1:0] main_ratio;
  reg main_prev;
  wire main_lvl = div_level(main_src, main_cnt, main_ratio);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      main_sel <= 2'b00;
      sub_sel <= 1'b0;
      aux_cnt <= 3'h0;
      main_cnt <= 3'h0;
      aux_ratio <= 2'b00;
      main_ratio <= 2'b00;
      main_prev <= 1'b0;
    end else begin
      main_prev <= main_src;
      // Switch only when old and new sources sit low: no runt pulse
      if (!main_lvl && !main_src && !main_req_src)
        main_sel <= main_sel_req;
      if (!sub_src && !sub_req_src)
        sub_sel <= sub_main_clock_select;
      if (aux_rise)
        aux_cnt <= aux_cnt + 3'h1;
      if (aux_cnt == 3'h0 && !aux_src)
        aux_ratio <= aux_div;
      if (main_src && !main_prev)
        main_cnt <= main_cnt + 3'h1;
      if (main_cnt == 3'h0 && !main_src)
        main_ratio <= main_div;
    end
  end

  // Registered clock outputs with gating
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_clock <= 1'b0;
      aux_clock_out <= 1'b0;
      main_clock_cpu <= 1'b0;
      main_clock_periph <= 1'b0;
      sub_main_clock <= 1'b0;
    end else begin
      aux_clock <= aux_src;
      aux_clock_out <= div_level(aux_src, aux_cnt, aux_ratio);
      // Gate only while low so a halt never clips a high phase
      if (!main_lvl || !processor_halt_bit)
        main_clock_cpu <= main_lvl && !processor_halt_bit;
      main_clock_periph <= main_lvl;
      if (!sub_src || !sub_main_clock_off_bit)
        sub_main_clock <= sub_src && !sub_main_clock_off_bit;
    end
  end

endmodule

// ### clock_ctrl_checker.sv
// Concurrent checks on the clock block ports, bound into the design top
`timescale 1ns/100ps
module clock_ctrl_checker #(
  parameter HAS_SECOND = 1,
  parameter LF_TIMEOUT_CYCLES = 12500
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic main_clock_cpu,
  input wire logic main_clock_periph,
  input wire logic sub_main_clock,
  input wire logic primary_osc_enable,
  input wire logic primary_hf_mode,
  input wire logic [1:0] load_capacitance_select,
  input wire logic very_low_power_enable,
  input wire logic second_osc_enable,
  input wire logic second_ext_clock_mode
);
  logic [7:0] osc_q;
  logic [10:0] sel_q;
  logic [3:0] mode_q;
  logic [7:0] quiet;
  logic wr;
  logic settled;
  logic unmapped;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Mirror of the settings; slow sources need a long quiet time before gating is judged
  assign wr = psel && penable && pwrite && pready;
  assign settled = (quiet == 8'hFF);
  assign unmapped = (paddr > 8'h14) || (paddr[1:0] != 2'h0);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_q <= 8'h02;
      sel_q <= 11'h000;
      mode_q <= 4'h0;
      quiet <= 8'h00;
    end else begin
      quiet <= wr ? 8'h00 : (settled ? quiet : quiet + 8'h01);
      if (wr && paddr == 8'h08) osc_q <= pwdata[7:0];
      if (wr && paddr == 8'h0C) sel_q <= pwdata[10:0];
      if (wr && paddr == 8'h10) mode_q <= pwdata[3:0];
    end
  end
  // Gating waits for a low phase, and a slow ring clock can stay high for hundreds of
  // cycles, so the processor clock is judged once the ungated copy has been low
  halt_gate_a: assert property (mode_q[3] && !main_clock_periph |=> !main_clock_cpu)
    else $error("processor clock runs while halted");
  sub_gate_a: assert property (settled && sel_q[5] |-> !sub_main_clock)
    else $error("sub-main clock runs while switched off");
  vlp_off_a: assert property (settled && mode_q[2] |-> !very_low_power_enable)
    else $error("very low power oscillator left on with crystal off");
  primary_off_a: assert property (settled && ((mode_q[2] && (sel_q[1:0] != 2'h3 || mode_q[3]))
    || (sel_q[8:7] == 2'h2 && !osc_q[3])) |-> !primary_osc_enable)
    else $error("primary oscillator left enabled");
  second_off_a: assert property (settled && sel_q[6] && (sel_q[1:0] != 2'h2 || mode_q[3])
    && (!sel_q[4] || sel_q[5]) |-> !second_osc_enable)
    else $error("second oscillator left enabled while unused");
  second_keep_a: assert property (settled && HAS_SECOND != 0 && sel_q[6] && sel_q[4]
    && !sel_q[5] |-> second_osc_enable)
    else $error("second oscillator stopped while feeding sub-main");
  hf_mode_a: assert property (settled |-> primary_hf_mode == osc_q[3])
    else $error("primary frequency mode differs from setting");
  load_cap_a: assert property (settled |-> load_capacitance_select == osc_q[5:4])
    else $error("load capacitance differs from setting");
  ext_mode_a: assert property (settled |-> second_ext_clock_mode == (sel_q[10:9] == 2'h3))
    else $error("second oscillator external mode wrong");
  bad_addr_a: assert property (psel && penable |-> pslverr == unmapped)
    else $error("slave error does not match address map");
endmodule

// ### osc_sources.sv
// Behavioural crystal and low power oscillators feeding the clock block
`timescale 1ns/100ps
module osc_sources #(
  parameter real PRI_HALF = 317.0,
  parameter real VLP_HALF = 803.0,
  parameter real SEC_HALF = 83.0
) (
  input wire logic primary_osc_enable,
  input wire logic very_low_power_enable,
  input wire logic second_osc_enable,
  input wire logic stall,
  output logic primary_crystal_clock,
  output logic very_low_power_clock,
  output logic second_crystal_clock
);
  // A stopped oscillator stands still low; stall mimics a dead primary crystal
  initial begin
    primary_crystal_clock = 1'b0;
    very_low_power_clock = 1'b0;
    second_crystal_clock = 1'b0;
  end
  always begin
    #(PRI_HALF);
    primary_crystal_clock = (primary_osc_enable && !stall) ? !primary_crystal_clock : 1'b0;
  end
  always begin
    #(VLP_HALF);
    very_low_power_clock = very_low_power_enable ? !very_low_power_clock : 1'b0;
  end
  always begin
    #(SEC_HALF);
    second_crystal_clock = second_osc_enable ? !second_crystal_clock : 1'b0;
  end
endmodule

// ### clock_source_select_gating_test.sv
// Self-checking bench for the clock block over APB
`timescale 1ns/100ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module clock_source_select_gating_test;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, stall, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, held;
  logic aux_clock, aux_clock_out, main_clock_cpu, main_clock_periph, sub_main_clock;
  logic ring_osc_clock, primary_osc_enable, primary_hf_mode, very_low_power_enable;
  logic second_osc_enable, second_ext_clock_mode, ring_osc_enable;
  logic primary_crystal_clock, very_low_power_clock, second_crystal_clock;
  logic [1:0] load_capacitance_select;
  logic [5:0] sig;
  int bad_count = 0;
  int check_count = 0;
  int c[6];
  int i;
  assign sig = {main_clock_cpu, second_crystal_clock, sub_main_clock, main_clock_periph,
    aux_clock_out, aux_clock};
  clock_source_select_gating #(.HAS_SECOND(1), .LF_TIMEOUT_CYCLES(200)) u_dut (.clk(clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_crystal_clock(primary_crystal_clock), .very_low_power_clock(very_low_power_clock),
    .second_crystal_clock(second_crystal_clock), .aux_clock(aux_clock),
    .aux_clock_out(aux_clock_out), .main_clock_cpu(main_clock_cpu),
    .main_clock_periph(main_clock_periph), .sub_main_clock(sub_main_clock),
    .ring_osc_clock(ring_osc_clock), .primary_osc_enable(primary_osc_enable),
    .primary_hf_mode(primary_hf_mode), .load_capacitance_select(load_capacitance_select),
    .very_low_power_enable(very_low_power_enable), .second_osc_enable(second_osc_enable),
    .second_ext_clock_mode(second_ext_clock_mode), .ring_osc_enable(ring_osc_enable));
  osc_sources u_osc (.primary_osc_enable(primary_osc_enable),
    .very_low_power_enable(very_low_power_enable), .second_osc_enable(second_osc_enable),
    .stall(stall), .primary_crystal_clock(primary_crystal_clock),
    .very_low_power_clock(very_low_power_clock), .second_crystal_clock(second_crystal_clock));
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end
  task print_verdict;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the edge that sees pready
  task apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin bad_count++; print_verdict(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb_xfer(1'b1, a, d); endtask
  task rdreg(input logic [7:0] a); apb_xfer(1'b0, a, 32'h00000000); endtask
  // Counts rising edges of the watched clocks over a fixed window
  task count_rises(input int n);
    logic [5:0] prev;
    c = '{default:0};
    prev = sig;
    repeat (n) begin
      @(posedge clk);
      for (int k = 0; k < 6; k++) if (sig[k] && !prev[k]) c[k]++;
      prev = sig;
    end
  endtask
  function automatic logic close(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  initial begin
    {psel, penable, pwrite, stall} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rdreg(8'h00); `CHECK(rd, 32'h0000001F)
    rdreg(8'h08); `CHECK(rd, 32'h00000002)
    rdreg(8'h0C); `CHECK(rd, 32'h00000000)
    rdreg(8'h14); `CHECK(rd[3], 1'b1)
    `CHECK(load_capacitance_select, 2'h0)
    rdreg(8'h18); `CHECK(er, 1'b1)
    wr(8'h00, 32'h0000003F); rdreg(8'h00); `CHECK(rd, 32'h0000003F)
    for (i = 0; i < 4; i++) begin
      wr(8'h08, 32'h02 | (i << 4)); rdreg(8'h08);
      `CHECK(load_capacitance_select, i[1:0])
    end
    // Fault flag cleared once the primary crystal has been seen running
    repeat (400) @(posedge clk);
    wr(8'h14, 32'h8); rdreg(8'h14); `CHECK(rd[3], 1'b0)
    for (i = 0; i < 4; i++) begin
      wr(8'h08, 32'h02 | (i << 6)); wr(8'h0C, 32'h3 | (i << 2));
      // A new ratio lands only at a counter wrap, up to eight source periods later
      repeat (800) @(posedge clk);
      count_rises(3200);
      `CHECK(close(c[0] >> i, c[1]), 1'b1)
      `CHECK(close(c[0] >> i, c[2]), 1'b1)
    end
    wr(8'h08, 32'h02); wr(8'h0C, 32'h2);
    repeat (800) @(posedge clk);
    count_rises(3200);
    `CHECK(close(c[4], c[2]), 1'b1)
    wr(8'h0C, 32'h103); count_rises(3200);
    `CHECK(primary_osc_enable, 1'b0)
    `CHECK(close(c[0], 16), 1'b1)
    `CHECK(very_low_power_enable, 1'b1)
    wr(8'h0C, 32'h3); wr(8'h08, 32'h0A); count_rises(300);
    `CHECK(primary_hf_mode, 1'b1)
    wr(8'h08, 32'h02); wr(8'h10, 32'h4); count_rises(300);
    `CHECK(primary_osc_enable, 1'b1)
    // Select the very low power clock so that only the crystal off bit can stop it
    wr(8'h0C, 32'h103); count_rises(300);
    `CHECK(very_low_power_enable, 1'b0)
    wr(8'h0C, 32'h3);
    wr(8'h10, 32'hC); count_rises(3200);
    `CHECK(primary_osc_enable, 1'b0)
    `CHECK(c[5], 0)
    wr(8'h10, 32'h0); wr(8'h0C, 32'h50);
    // Sub-main switches only when the ring clock is low, which may take a while
    repeat (800) @(posedge clk);
    count_rises(3200);
    `CHECK(second_osc_enable, 1'b1)
    `CHECK(close(c[3], c[4]), 1'b1)
    wr(8'h0C, 32'h70); count_rises(3200);
    `CHECK(second_osc_enable, 1'b0)
    `CHECK(c[3], 0)
    wr(8'h0C, 32'h600); count_rises(300);
    `CHECK(second_ext_clock_mode, 1'b1)
    wr(8'h0C, 32'h0); wr(8'h10, 32'h1); rdreg(8'h04);
    held = rd;
    count_rises(500); rdreg(8'h04); `CHECK(rd[9:0], held[9:0])
    wr(8'h10, 32'h0); count_rises(60); rdreg(8'h04);
    `CHECK(close(int'(rd[9:0]), int'(held[9:0])), 1'b1)
    // A dead primary crystal keeps the low frequency fault and the flag set
    stall <= 1'b1;
    count_rises(600); wr(8'h14, 32'h8); rdreg(8'h14);
    `CHECK(rd[0], 1'b1)
    `CHECK(rd[3], 1'b1)
    stall <= 1'b0;
    print_verdict();
  end
endmodule
bind clock_source_select_gating clock_ctrl_checker #(.HAS_SECOND(HAS_SECOND),
  .LF_TIMEOUT_CYCLES(LF_TIMEOUT_CYCLES)) u_chk (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .main_clock_cpu(main_clock_cpu), .main_clock_periph(main_clock_periph),
  .sub_main_clock(sub_main_clock),
  .primary_osc_enable(primary_osc_enable), .primary_hf_mode(primary_hf_mode),
  .load_capacitance_select(load_capacitance_select),
  .very_low_power_enable(very_low_power_enable), .second_osc_enable(second_osc_enable),
  .second_ext_clock_mode(second_ext_clock_mode));
